//--- src/uadsr_defines.vh
/*
 * register offsets, field positions, reset values and mode codes of the
 * serial data and status register block.
 * assumes inclusion by bare name from the block's single design file.
 */
`ifndef UADSR_DEFINES_VH
`define UADSR_DEFINES_VH

// word indexes; byte address is four times the index
`define UADSR_IDX_RX_LOW      4'h0
`define UADSR_IDX_RX_HIGH     4'h1
`define UADSR_IDX_TX_LOW      4'h2
`define UADSR_IDX_TX_NINTH    4'h3
`define UADSR_IDX_FLAGS       4'h4
`define UADSR_IDX_IRQ_CTRL    4'h5
`define UADSR_IDX_MODE_CTRL   4'h6
`define UADSR_IDX_FRAME_CTRL  4'h7

// serial_flags bit positions
`define UADSR_F_RXC           7
`define UADSR_F_TXC           6
`define UADSR_F_DRE           5
`define UADSR_F_RXS           4
`define UADSR_F_ISF           3
`define UADSR_F_BDF           1
`define UADSR_F_WFB           0

// interrupt_enable_control bit positions
`define UADSR_E_RXC           7
`define UADSR_E_TXC           6
`define UADSR_E_DRE           5
`define UADSR_E_RXS           4
`define UADSR_E_ABE           2

// mode control fields
`define UADSR_M_RXEN          7
`define UADSR_M_TXEN          6
`define UADSR_M_SFDEN         4

// receiver mode codes
`define UADSR_RXM_NORMAL      2'h0
`define UADSR_RXM_DOUBLE      2'h1
`define UADSR_RXM_GENERIC_AUTOBAUD_MODE     2'h2
`define UADSR_RXM_LIN_AUTOBAUD_MODE     2'h3

// character size codes
`define UADSR_CS_5BIT         3'h0
`define UADSR_CS_6BIT         3'h1
`define UADSR_CS_7BIT         3'h2
`define UADSR_CS_8BIT         3'h3
`define UADSR_CS_NINE_BIT_SIZE_LOW     3'h6
`define UADSR_CS_NINE_BIT_SIZE_HIGH    3'h7
`define UADSR_CMODE_MSPI      2'h3

`define UADSR_FRAME_RESET     8'h03
`define UADSR_ZERO8           8'h00
`define UADSR_BREAK_BITS      4'hB
`define UADSR_LIN_SYNC        8'h55

`endif

//--- src/uadsr_regs.v
/*
 * register side of the serial transceiver: two-entry receive fifo with
 * per-character flags, transmit holding buffer, status flags, interrupt
 * enables and mode bytes, on an avalon-mm slave with waitrequest.
 * assumes the frame engine delivers received characters as one-cycle
 * strobes with their stop/parity/ninth-bit status and raises events for
 * start, break, sync and shifter completion; inputs are synchronous to clk.
 */
// Design decision made here: the Avalon-MM register port.
`include "uadsr_defines.vh"

module uadsr_regs (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        rx_char_valid,
   input  wire [8:0]  rx_char_data,
   input  wire        rx_char_stop_bit,
   input  wire        rx_char_parity_bad,
   input  wire        rx_char_is_response,
   input  wire        rx_shifter_full,
   input  wire        rx_start_bit,
   input  wire        rx_start_edge_standby,
   input  wire        rx_break_sync_ok,
   input  wire        rx_sync_bad,
   input  wire        rxd_low_high_edge,
   input  wire        tx_shifter_empty,
   input  wire        tx_frame_done,
   input  wire        txc_vector_ack,
   output reg         tx_load,
   output reg  [8:0]  tx_load_data,
   output reg         autobaud_reset,
   output reg         await_break_arm,
   output reg         rxc_irq,
   output reg         dre_irq,
   output reg         txc_irq,
   output reg  [7:0]  mode_control,
   output reg  [7:0]  frame_control,
   output reg  [7:0]  interrupt_enable_control
);

   // receive fifo: entry holds stop error, parity fault, ninth bit, data
   reg  [11:0] receive_fifo [0:1];
   reg  [1:0]  rx_count;
   reg         overflow_flag;
   reg  [7:0]  transmit_holding_buffer;
   reg         transmit_ninth_bit;
   reg         tx_buffer_empty_flag;
   reg         send_done_flag;
   reg         start_seen_flag;
   reg         bad_sync_flag;
   reg         break_seen_flag;
   reg         wr_cycle;
   reg  [7:0]  rd_byte;
   reg  [11:0] next_entry;
   reg  [7:0]  masked_data;

   wire [1:0] lin_mode_bits = mode_control[2:1];
   wire       lin_mode      = (lin_mode_bits == `UADSR_RXM_LIN_AUTOBAUD_MODE);
   wire       auto_mode     = lin_mode_bits[1];
   wire       mspi_mode     = (frame_control[7:6] == `UADSR_CMODE_MSPI);
   wire       parity_on     = frame_control[5];
   wire [3:0] idx           = avs_address[5:2];
   wire       acc_go        = (avs_read | avs_write) & avs_waitrequest & ~wr_cycle;
   wire       wr_go         = acc_go & avs_write & avs_byteenable[0];
   wire       rd_go         = acc_go & avs_read;
   wire [7:0] wbyte         = avs_writedata[7:0];
   wire       rx_pop        = rd_go & (idx == `UADSR_IDX_RX_LOW) & (rx_count != 2'd0);
   wire       rx_push       = rx_char_valid & mode_control[`UADSR_M_RXEN];
   wire       tx_move       = ~tx_buffer_empty_flag & tx_shifter_empty
                              & mode_control[`UADSR_M_TXEN];
   wire       wr_flags      = wr_go & (idx == `UADSR_IDX_FLAGS);

   // clears upper data bits above the character size
   function [7:0] size_mask;
      input [2:0] cs;
      begin
         case (cs)
            `UADSR_CS_5BIT: size_mask = 8'h1F;
            `UADSR_CS_6BIT: size_mask = 8'h3F;
            `UADSR_CS_7BIT: size_mask = 8'h7F;
            default:        size_mask = 8'hFF;
         endcase
      end
   endfunction

   // builds the buffered entry from the frame engine's status
   always @* begin
      masked_data = rx_char_data[7:0] & size_mask(frame_control[2:0]);
      next_entry  = {1'b0,
                     ~rx_char_stop_bit & ~mspi_mode,
                     rx_char_parity_bad & (parity_on | lin_mode) & ~mspi_mode,
                     lin_mode ? rx_char_is_response
                              : (rx_char_data[8] & frame_control[2]),
                     masked_data};
   end

   // receive fifo; head always in slot 0
   always @(posedge clk) begin
      if (sys_rst || !mode_control[`UADSR_M_RXEN]) begin
         rx_count        <= 2'd0;
         receive_fifo[0] <= 12'h000;
         receive_fifo[1] <= 12'h000;
         overflow_flag   <= 1'b0;
      end else begin
         if (rx_pop) begin
            receive_fifo[0] <= (rx_push && rx_count == 2'd1) ? next_entry : receive_fifo[1];
            if (rx_push && rx_count == 2'd2)
               receive_fifo[1] <= next_entry;
            rx_count      <= rx_push ? rx_count : rx_count - 2'd1;
            overflow_flag <= 1'b0;
         end else if (rx_push && rx_count != 2'd2) begin
            receive_fifo[rx_count[0]] <= next_entry;
            rx_count <= rx_count + 2'd1;
         end
         if (rx_count == 2'd2 && rx_shifter_full && rx_start_bit && !mspi_mode)
            overflow_flag <= 1'b1;
      end
   end

   // transmit buffer and status flags
   always @(posedge clk) begin
      if (sys_rst) begin
         transmit_holding_buffer  <= `UADSR_ZERO8;
         transmit_ninth_bit       <= 1'b0;
         tx_buffer_empty_flag     <= 1'b1;
         send_done_flag           <= 1'b0;
         start_seen_flag          <= 1'b0;
         bad_sync_flag            <= 1'b0;
         break_seen_flag          <= 1'b0;
         tx_load                  <= 1'b0;
         tx_load_data             <= 9'h000;
         autobaud_reset           <= 1'b0;
         await_break_arm          <= 1'b0;
         mode_control             <= `UADSR_ZERO8;
         frame_control            <= `UADSR_FRAME_RESET;
         interrupt_enable_control <= `UADSR_ZERO8;
      end else begin
         tx_load         <= tx_move;
         autobaud_reset  <= wr_flags & wbyte[`UADSR_F_ISF];
         await_break_arm <= wr_flags & wbyte[`UADSR_F_WFB];
         if (tx_move) begin
            tx_load_data         <= {transmit_ninth_bit,
                                     transmit_holding_buffer & size_mask(frame_control[2:0])};
            tx_buffer_empty_flag <= 1'b1;
         end
         if (wr_go && idx == `UADSR_IDX_TX_LOW && tx_buffer_empty_flag) begin
            transmit_holding_buffer <= wbyte;
            tx_buffer_empty_flag    <= 1'b0;
         end
         if (wr_go && idx == `UADSR_IDX_TX_NINTH)
            transmit_ninth_bit <= wbyte[0];
         if (wr_go && idx == `UADSR_IDX_IRQ_CTRL)
            interrupt_enable_control <= wbyte;
         if (wr_go && idx == `UADSR_IDX_MODE_CTRL)
            mode_control <= wbyte & 8'hDF;
         if (wr_go && idx == `UADSR_IDX_FRAME_CTRL)
            frame_control <= wbyte;
         // set wins over clear for every flag below
         if ((wr_flags && wbyte[`UADSR_F_TXC]) || txc_vector_ack)
            send_done_flag <= 1'b0;
         if (tx_frame_done && tx_buffer_empty_flag && !tx_move)
            send_done_flag <= 1'b1;
         if (wr_flags && wbyte[`UADSR_F_RXS])
            start_seen_flag <= 1'b0;
         if (rx_start_edge_standby && mode_control[`UADSR_M_SFDEN] && !mspi_mode)
            start_seen_flag <= 1'b1;
         if (wr_flags && wbyte[`UADSR_F_ISF])
            bad_sync_flag <= 1'b0;
         if (rx_sync_bad && auto_mode)
            bad_sync_flag <= 1'b1;
         if ((wr_flags && wbyte[`UADSR_F_BDF]) || rx_push)
            break_seen_flag <= 1'b0;
         if (rx_break_sync_ok && auto_mode)
            break_seen_flag <= 1'b1;
      end
   end

   // read mux
   always @* begin
      case (idx)
         `UADSR_IDX_RX_LOW:     rd_byte = receive_fifo[0][7:0];
         `UADSR_IDX_RX_HIGH:    rd_byte = {rx_count != 2'd0, overflow_flag, 3'b000,
                                           receive_fifo[0][10] & (rx_count != 2'd0),
                                           receive_fifo[0][9] & (rx_count != 2'd0)
                                              & (parity_on | lin_mode),
                                           receive_fifo[0][8] & (rx_count != 2'd0)};
         `UADSR_IDX_TX_LOW:     rd_byte = transmit_holding_buffer;
         `UADSR_IDX_TX_NINTH:   rd_byte = {7'h00, transmit_ninth_bit};
         `UADSR_IDX_FLAGS:      rd_byte = {rx_count != 2'd0, send_done_flag,
                                           tx_buffer_empty_flag,
                                           start_seen_flag & mode_control[`UADSR_M_SFDEN],
                                           bad_sync_flag, 1'b0, break_seen_flag, 1'b0};
         `UADSR_IDX_IRQ_CTRL:   rd_byte = interrupt_enable_control;
         `UADSR_IDX_MODE_CTRL:  rd_byte = mode_control;
         `UADSR_IDX_FRAME_CTRL: rd_byte = frame_control;
         default:               rd_byte = `UADSR_ZERO8;
      endcase
   end

   // bus handshake: one wait cycle, then answer with waitrequest low
   always @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         wr_cycle        <= 1'b0;
      end else begin
         wr_cycle        <= acc_go;
         avs_waitrequest <= ~acc_go;
         if (rd_go)
            avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // interrupt requests follow flag and enable
   always @(posedge clk) begin
      if (sys_rst) begin
         rxc_irq <= 1'b0;
         dre_irq <= 1'b0;
         txc_irq <= 1'b0;
      end else begin
         rxc_irq <= ((rx_count != 2'd0) & interrupt_enable_control[`UADSR_E_RXC])
                  | (start_seen_flag & mode_control[`UADSR_M_SFDEN]
                     & interrupt_enable_control[`UADSR_E_RXS])
                  | (bad_sync_flag & interrupt_enable_control[`UADSR_E_ABE]);
         dre_irq <= tx_buffer_empty_flag & interrupt_enable_control[`UADSR_E_DRE];
         txc_irq <= send_done_flag & interrupt_enable_control[`UADSR_E_TXC];
      end
   end

endmodule // uadsr_regs

//--- tb/uadsr_regs_monitor.sv
/* port assertions for the serial data and status register block.
   assumes binding onto uadsr_regs, one clock, synchronous reset. */
module uadsr_mon (
   input logic        clk,
   input logic        sys_rst,
   input logic [5:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0]  avs_byteenable,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        rx_char_valid,
   input logic        tx_shifter_empty,
   input logic        tx_load,
   input logic        autobaud_reset,
   input logic        await_break_arm,
   input logic        rxc_irq,
   input logic        dre_irq,
   input logic        txc_irq,
   input logic [7:0]  mode_control,
   input logic [7:0]  frame_control,
   input logic [7:0]  interrupt_enable_control
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [3:0] idx = avs_address[5:2];
   wire [7:0] ien = interrupt_enable_control;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   bus_answer_a: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
      else $error("bus request not answered");
   rxc_src_a: assert property (rxc_irq |-> $past(ien[7] | ien[4] | ien[2]))
      else $error("receive irq without enable");
   irq_gate_a: assert property ((dre_irq |-> $past(ien[5])) and (txc_irq |-> $past(ien[6])))
      else $error("transmit irq without enable");
   rx_irq_a: assert property (rx_char_valid && mode_control[7] && ien[7] |-> ##[1:2] rxc_irq)
      else $error("received char raised no irq");
   flush_a: assert property ((!mode_control[7] && !ien[4] && !ien[2]) [*2] |=> !rxc_irq)
      else $error("receive irq with receiver off");
   tx_gate_a: assert property (tx_load |-> $past(tx_shifter_empty && mode_control[6]))
      else $error("load into busy or disabled shifter");
   arm_a: assert property (avs_write && !avs_waitrequest && idx == 4'h4 && avs_byteenable[0]
      && avs_writedata[0] |-> ##[0:1] await_break_arm)
      else $error("await break not armed");
   sync_a: assert property (avs_write && !avs_waitrequest && idx == 4'h4 && avs_byteenable[0]
      && avs_writedata[3] |-> ##[0:1] autobaud_reset)
      else $error("bad sync clear gave no idle return");
   flags_rd_a: assert property (avs_read && !avs_waitrequest && idx == 4'h4
      |-> avs_readdata[31:8] == 24'h00_0000 && !avs_readdata[0])
      else $error("flags read nonzero in fixed bits");
   parity_fault_flag_off_a: assert property (avs_read && !avs_waitrequest && idx == 4'h1
      && frame_control[5:4] == 2'b00 && mode_control[2:1] != 2'b11 |-> !avs_readdata[1])
      else $error("parity fault with checking off");
endmodule // uadsr_mon
bind uadsr_regs uadsr_mon mon (.*);

//--- tb/uadsr_node.sv
/* behavioural far-side node: hands received characters in and shifts
   transmit frames out. assumes the bench calls send and sets frame_len. */
module uadsr_node (
   input  logic       clk,
   input  logic       sys_rst,
   input  logic [7:0] frame_len,
   input  logic       tx_load,
   input  logic [8:0] tx_load_data,
   output logic       rx_char_valid,
   output logic [8:0] rx_char_data,
   output logic       rx_char_stop_bit,
   output logic       rx_char_parity_bad,
   output logic       rx_char_is_response,
   output logic       tx_shifter_empty,
   output logic       tx_frame_done,
   output logic [8:0] last_tx,
   output logic [3:0] n_tx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   initial {rx_char_valid, rx_char_data, rx_char_stop_bit, rx_char_parity_bad,
      rx_char_is_response} = 13'h0000;
   task send(input logic [8:0] d, input logic s, input logic p, input logic r);
      @(posedge clk);
      {rx_char_valid, rx_char_data, rx_char_stop_bit, rx_char_parity_bad,
         rx_char_is_response} <= {1'b1, d, s, p, r};
      @(posedge clk);
      // released fields show the inverse, never the old value
      {rx_char_valid, rx_char_data, rx_char_stop_bit, rx_char_parity_bad,
         rx_char_is_response} <= {1'b0, ~d, ~s, ~p, ~r};
   endtask
   always @(posedge clk) begin
      if (sys_rst) begin
         {cnt, tx_frame_done, n_tx, last_tx} <= 22'h00_0000;
         tx_shifter_empty <= 1'b1;
      end else begin
         tx_frame_done <= 1'b0;
         if (tx_load) begin
            tx_shifter_empty <= 1'b0;
            cnt <= frame_len;
            last_tx <= tx_load_data;
            n_tx <= n_tx + 4'h1;
         end else if (!tx_shifter_empty && cnt == 8'h00) begin
            tx_shifter_empty <= 1'b1;
            tx_frame_done <= 1'b1;
         end else if (!tx_shifter_empty) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule // uadsr_node

//--- tb/uart_data_status_registers_tb.sv
/* self-checking bench for the serial register block.
   assumes the node model on the frame-engine side. */
module uart_data_status_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, rx_shifter_full = 0;
   logic [5:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, seed = 32'hf4e2_4694;
   logic [3:0] avs_byteenable = 4'hF, n_tx;
   logic [4:0] ev = 0;
   logic [7:0] frame_len = 8'h28, rdv, mode_control, frame_control, interrupt_enable_control;
   logic [8:0] rx_char_data, tx_load_data, last_tx;
   logic [2:0] cs, sz [0:4] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   wire rxd_low_high_edge = 1'b0;
   wire txc_vector_ack, rx_start_bit, rx_start_edge_standby, rx_break_sync_ok, rx_sync_bad;
   wire avs_waitrequest, rx_char_valid, rx_char_stop_bit, rx_char_parity_bad;
   wire rx_char_is_response, tx_shifter_empty, tx_frame_done, tx_load, autobaud_reset;
   wire await_break_arm, rxc_irq, dre_irq, txc_irq;
   integer i, err_total = 0, n_checks = 0;
   assign {txc_vector_ack, rx_start_bit, rx_start_edge_standby, rx_break_sync_ok,
      rx_sync_bad} = ev;
   uadsr_regs dut (.*);
   uadsr_node nd (.*);
   initial forever #12.5 clk = ~clk;
   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [7:0] hi(input logic [8:0] d, input logic s, p, input logic [2:0] c);
      hi = {1'b1, 4'h0, !s, p, c[2] & d[8]};
   endfunction
   function logic [7:0] lo(input logic [8:0] d, input logic [2:0] c);
      lo = c[2] ? d[7:0] : d[7:0] & (8'hFF >> (2'd3 - c[1:0]));
   endfunction
   task chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         err_total++;
      end
   endtask
   task bus(input logic w, input logic [3:0] x, input logic [7:0] d);
      @(posedge clk);
      avs_address <= {x, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rdv = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task wr(input logic [3:0] x, input logic [7:0] d);
      bus(1'b1, x, d);
   endtask
   task rc(input logic [3:0] x, input logic [7:0] e);
      bus(1'b0, x, 8'h00);
      chk8(rdv, e);
   endtask
   task pulse(input logic [4:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 5'h00;
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rc(4'h1, 8'h00);
      rc(4'h4, 8'h20);
      rc(4'h5, 8'h00);
      rc(4'h7, 8'h03);
      rc(4'h9, 8'h00);
      wr(4'h5, 8'hE0);
      wr(4'h6, 8'hC0);
      for (i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         cs = sz[i % 5];
         wr(4'h7, {5'h04, cs});
         nd.send(seed[8:0], seed[9], seed[10], 1'b0);
         nd.send(seed[20:12], seed[21], 1'b0, 1'b0);
         rc(4'h1, hi(seed[8:0], seed[9], seed[10], cs));
         rc(4'h0, lo(seed[8:0], cs));
         rc(4'h1, hi(seed[20:12], seed[21], 1'b0, cs));
         rc(4'h0, lo(seed[20:12], cs));
         rc(4'h1, 8'h00);
      end
      wr(4'h7, 8'h03);
      nd.send(9'h0A5, 1'b1, 1'b1, 1'b0);
      nd.send(9'h03C, 1'b1, 1'b0, 1'b0);
      @(posedge clk) rx_shifter_full <= 1'b1;
      pulse(5'h08);
      rc(4'h1, 8'hC0);
      rc(4'h0, 8'hA5);
      rx_shifter_full <= 1'b0;
      rc(4'h0, 8'h3C);
      nd.send(9'h011, 1'b0, 1'b0, 1'b0);
      wr(4'h6, 8'h40);
      wr(4'h6, 8'hC0);
      rc(4'h1, 8'h00);
      wr(4'h6, 8'hC6);
      nd.send(9'h011, 1'b1, 1'b1, 1'b0);
      nd.send(9'h022, 1'b1, 1'b0, 1'b1);
      rc(4'h1, 8'h82);
      rc(4'h0, 8'h11);
      rc(4'h1, 8'h81);
      rc(4'h0, 8'h22);
      wr(4'h6, 8'hC0);
      pulse(5'h06);
      rc(4'h4, 8'h20);
      wr(4'h6, 8'hD4);
      pulse(5'h06);
      rc(4'h4, 8'h32);
      wr(4'h4, 8'h10);
      nd.send(9'h077, 1'b1, 1'b0, 1'b0);
      rc(4'h4, 8'hA0);
      rc(4'h0, 8'h77);
      pulse(5'h01);
      rc(4'h4, 8'h28);
      wr(4'h4, 8'h09);
      rc(4'h4, 8'h20);
      wr(4'h6, 8'hC0);
      wr(4'h3, 8'h00);
      wr(4'h2, seed[7:0]);
      rc(4'h4, 8'h20);
      chk8(last_tx[7:0], seed[7:0]);
      wr(4'h2, seed[15:8]);
      rc(4'h4, 8'h00);
      wr(4'h2, 8'h5A);
      while (n_tx !== 4'h2) @(posedge clk);
      chk8(last_tx[7:0], seed[15:8]);
      while (tx_shifter_empty !== 1'b1) @(posedge clk);
      rc(4'h4, 8'h60);
      chk8({5'h00, rxc_irq, dre_irq, txc_irq}, 8'h03);
      pulse(5'h10);
      rc(4'h4, 8'h20);
      end_sim();
   end
endmodule // uart_data_status_registers_tb
